// file: hw/fns_synth_ctrl.sv
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "fns_regs.svh"
module fns_synth_ctrl import fns_pkg::*; (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Avalon-MM register slave
    input wire logic [6:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Pins and analog status
    input wire logic i_chip_enable_pin,
    input wire logic i_mode_pin,
    input wire logic i_pd_clk,
    input wire logic i_osc_fast,
    input wire logic [4:0] i_osc_gain_code,
    // Oscillator and LO controls
    output logic [2:0] o_osc_enable,
    output logic [6:0] o_osc_band,
    output logic [4:0] o_coarse_tune_voltage,
    output logic [3:0] o_osc_core_current,
    output logic o_lo_div4,
    output logic [3:0] o_lo_buffer_current,
    // Loop controls
    output logic [2:0] o_ref_div_ratio,
    output logic [9:0] o_feedback_ratio,
    output logic [4:0] o_pump_current,
    output logic o_pump_low_current,
    output logic [1:0] o_freq_loop_factor,
    output logic o_amp_enable,
    output logic o_filter_pin_oe,
    output logic o_detector_polarity,
    // Status
    output logic o_cal_busy,
    output logic o_lock_enable
);
    localparam int NPIN = 4;

    fns_core_if core ();

    // Pin synchronisers: bit 0 chip enable, 1 mode, 2 detector clock, 3 comparator.
    wire [NPIN-1:0] pin_f;
    logic [NPIN-1:0] pin_q_r;
    logic [NPIN-1:0] pin_raw;
    assign pin_raw = {i_osc_fast, i_pd_clk, i_mode_pin, i_chip_enable_pin};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            logic [2:0] sh_r;
            logic filt_r;
            always_ff @(posedge i_core_clk) begin
                if (!i_reset_n) begin
                    sh_r <= 3'h0;
                    filt_r <= 1'b0;
                end else begin
                    sh_r <= {sh_r[1:0], pin_raw[gi]};
                    if (sh_r[1] == sh_r[2]) begin
                        filt_r <= sh_r[2];
                    end
                end
            end
            assign pin_f[gi] = filt_r;
        end
    endgenerate

    always_ff @(posedge i_core_clk) begin : p_edge
        if (!i_reset_n) begin
            pin_q_r <= '0;
        end else begin
            pin_q_r <= pin_f;
        end
    end

    logic ce_rise;
    logic pd_tick;
    logic bank_sel;
    assign ce_rise = pin_f[0] && !pin_q_r[0];
    assign pd_tick = pin_f[2] && !pin_q_r[2];
    assign bank_sel = pin_f[1];

    // Register storage: two banks of five words and two common words.
    logic [15:0] bank_r [0:1][0:4];
    logic [15:0] cfg_one_r;
    logic [15:0] cfg_five_r;
    logic wait_r;
    logic [31:0] rdata_r;
    logic wr_take;
    logic bank_hit;
    assign wr_take = i_avs_write && !wait_r;
    assign bank_hit = i_avs_address[1:0] == 2'h0 && !i_avs_address[6] && i_avs_address[4:2] <= 3'h4;

    function automatic logic [15:0] rst_word(input logic [2:0] w);
        case (w)
            3'h0: rst_word = `FNS_RST_BANK_CFG;
            3'h4: rst_word = `FNS_RST_BANK_PMP;
            default: rst_word = `FNS_RST_ZERO;
        endcase
    endfunction : rst_word

    function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
        be_merge = old;
        if (be[0]) begin
            be_merge[7:0] = wd[7:0];
        end
        if (be[1]) begin
            be_merge[15:8] = wd[15:8];
        end
    endfunction : be_merge

    always_ff @(posedge i_core_clk) begin : p_regs
        if (!i_reset_n) begin
            for (int b = 0; b < 2; b++) begin
                for (int w = 0; w < 5; w++) begin
                    bank_r[b][w] <= rst_word(3'(w));
                end
            end
            cfg_one_r <= `FNS_RST_CFG_ONE;
            cfg_five_r <= `FNS_RST_ZERO;
        end else if (wr_take) begin
            if (bank_hit) begin
                bank_r[i_avs_address[5]][i_avs_address[4:2]] <=
                    be_merge(bank_r[i_avs_address[5]][i_avs_address[4:2]], i_avs_writedata, i_avs_byteenable);
            end else if (i_avs_address == `FNS_OFF_CFG_ONE) begin
                cfg_one_r <= be_merge(cfg_one_r, i_avs_writedata, i_avs_byteenable);
            end else if (i_avs_address == `FNS_OFF_CFG_FIVE) begin
                cfg_five_r <= be_merge(cfg_five_r, i_avs_writedata, i_avs_byteenable);
            end
        end
    end

    // Active bank fields, common-word fields and the failure flag.
    logic [15:0] act_cfg;
    logic [15:0] act_pmp;
    logic [1:0] osc_sel;
    logic cal_en;
    fns_band_t stored_band;
    logic autobw;
    logic byp;
    logic [2:0] rdiv;
    logic cal_fail;
    assign act_cfg = bank_r[bank_sel][0];
    assign act_pmp = bank_r[bank_sel][4];
    assign osc_sel = act_cfg[`FNS_F_OSC_SEL +: 2];
    assign cal_en = act_cfg[`FNS_F_CAL_EN];
    assign stored_band = act_cfg[`FNS_F_DEF_BAND +: 7];
    assign autobw = act_pmp[`FNS_F_AUTO_BW];
    assign byp = cfg_one_r[`FNS_F_BYP];
    assign rdiv = cfg_one_r[`FNS_F_RDIV +: 3];
    assign cal_fail = core.result == `FNS_BAND_MIN || core.result == `FNS_BAND_MAX;

    function automatic logic [15:0] rd_word(input logic [6:0] a);
        rd_word = 16'h0000;
        if (a[1:0] == 2'h0 && !a[6] && a[4:2] <= 3'h4) begin
            rd_word = bank_r[a[5]][a[4:2]];
        end else if (a == `FNS_OFF_CFG_ONE) begin
            rd_word = cfg_one_r;
        end else if (a == `FNS_OFF_CFG_FIVE) begin
            rd_word = cfg_five_r;
        end else if (a == `FNS_OFF_READBACK) begin
            rd_word = {6'h00, bank_sel, cal_fail, core.busy, core.result};
        end
    endfunction : rd_word

    // One wait state: waitrequest drops for one cycle per request.
    always_ff @(posedge i_core_clk) begin : p_bus
        if (!i_reset_n) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h00000000;
        end else begin
            wait_r <= !((i_avs_read || i_avs_write) && wait_r);
            if (i_avs_read && wait_r) begin
                rdata_r <= {16'h0000, rd_word(i_avs_address)};
            end
        end
    end

    // Calibration and fractional divider hookup.
    logic start_r;
    always_ff @(posedge i_core_clk) begin : p_start
        if (!i_reset_n) begin
            start_r <= 1'b0;
        end else begin
            start_r <= ce_rise && cal_en;
        end
    end

    assign core.start = start_r;
    assign core.pd_tick = pd_tick;
    assign core.osc_fast = pin_f[3];
    assign core.int_word = bank_r[bank_sel][1][9:0];
    assign core.frac_word = {bank_r[bank_sel][2], bank_r[bank_sel][3][7:0]};

    fns_band_cal u_cal (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .cal(core.cal)
    );

    fns_frac_seq u_frac (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .frac(core.frac)
    );

    // Output registers.
    logic [2:0] osc_en_r;
    fns_band_t band_r;
    logic [4:0] ctv_r;
    logic [3:0] vcoi_r;
    logic lo_div4_r;
    logic [3:0] lo_buf_r;
    logic [2:0] ref_div_r;
    logic [4:0] pump_r;
    logic lowi_r;
    logic [1:0] fll_r;
    logic amp_r;
    logic pdp_r;
    logic busy_r;
    logic lock_r;

    always_ff @(posedge i_core_clk) begin : p_osc
        if (!i_reset_n) begin
            osc_en_r <= 3'h1;
            band_r <= `FNS_BAND_MIN;
            ctv_r <= 5'h10;
            vcoi_r <= 4'h0;
            lo_div4_r <= 1'b0;
            lo_buf_r <= 4'h0;
        end else begin
            case (osc_sel)
                2'h2: osc_en_r <= 3'h2;
                2'h3: osc_en_r <= 3'h4;
                default: osc_en_r <= 3'h1;
            endcase
            if (!cal_en) begin
                band_r <= stored_band;
            end else if (core.busy) begin
                band_r <= core.trial_band;
            end else begin
                band_r <= core.result;
            end
            ctv_r <= act_cfg[`FNS_F_CT_V +: 5];
            vcoi_r <= act_pmp[`FNS_F_VCOI +: 4];
            lo_div4_r <= act_cfg[`FNS_F_LO_DIV];
            lo_buf_r <= cfg_five_r[3:0];
        end
    end

    always_ff @(posedge i_core_clk) begin : p_loop
        if (!i_reset_n) begin
            ref_div_r <= 3'h2;
            pump_r <= 5'h1f;
            lowi_r <= 1'b0;
            fll_r <= 2'h1;
            amp_r <= 1'b1;
            pdp_r <= 1'b1;
        end else begin
            if (byp) begin
                ref_div_r <= 3'h1;
            end else if (rdiv < 3'h2) begin
                ref_div_r <= 3'h2;
            end else begin
                ref_div_r <= rdiv;
            end
            pump_r <= autobw ? i_osc_gain_code : act_pmp[4:0];
            lowi_r <= act_pmp[`FNS_F_LOW_I];
            fll_r <= act_pmp[`FNS_F_FLL +: 2];
            amp_r <= cfg_one_r[`FNS_F_ACTIVE_FILTER_ENABLE];
            pdp_r <= cfg_one_r[`FNS_F_PDP];
        end
    end

    always_ff @(posedge i_core_clk) begin : p_status
        if (!i_reset_n) begin
            busy_r <= 1'b0;
            lock_r <= 1'b0;
        end else begin
            busy_r <= core.busy || start_r;
            lock_r <= pin_f[0] && !core.busy && !start_r && !(ce_rise && cal_en);
        end
    end

    assign o_avs_readdata = rdata_r;
    assign o_avs_waitrequest = wait_r;
    assign o_osc_enable = osc_en_r;
    assign o_osc_band = band_r;
    assign o_coarse_tune_voltage = ctv_r;
    assign o_osc_core_current = vcoi_r;
    assign o_lo_div4 = lo_div4_r;
    assign o_lo_buffer_current = lo_buf_r;
    assign o_ref_div_ratio = ref_div_r;
    assign o_feedback_ratio = core.ratio;
    assign o_pump_current = pump_r;
    assign o_pump_low_current = lowi_r;
    assign o_freq_loop_factor = fll_r;
    assign o_amp_enable = amp_r;
    assign o_filter_pin_oe = amp_r;
    assign o_detector_polarity = pdp_r;
    assign o_cal_busy = busy_r;
    assign o_lock_enable = lock_r;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    a_osc_pick: assert property ($past(osc_sel) == 2'h3 |-> o_osc_enable == 3'h4)
        else $error("third core not enabled alone");
    a_cal_trigger: assert property (ce_rise && cal_en |=> core.start ##1 core.busy)
        else $error("chip enable rise did not start selection");
    a_lock_after: assert property ($fell(core.busy) && pin_f[0] && !start_r && !ce_rise |=> o_lock_enable)
        else $error("lock not enabled after selection");
    a_fail_read: assert property (i_avs_read && wait_r && i_avs_address == `FNS_OFF_READBACK
        |=> o_avs_readdata[8] == ($past(core.result) == 7'h00 || $past(core.result) == 7'h7f))
        else $error("failure flag wrong");
    a_band_override: assert property ($past(!cal_en) |-> o_osc_band == $past(stored_band))
        else $error("stored band not applied");
    a_reset_vals: assert property ($past(!i_reset_n) |-> bank_r[1][0][15:11] == 5'h10
        && bank_r[1][4][4:0] == 5'h1f && bank_r[1][4][8:7] == 2'h1 && !bank_r[1][4][6])
        else $error("reset defaults wrong");
    a_lo_divide: assert property (o_lo_div4 == $past(act_cfg[`FNS_F_LO_DIV]))
        else $error("LO divide not following field");
    a_ref_bypass: assert property ($past(byp) |-> o_ref_div_ratio == 3'h1)
        else $error("bypass not divide by one");
    a_ref_value: assert property ($past(!byp && rdiv >= 3'h2) |-> o_ref_div_ratio == $past(rdiv))
        else $error("reference ratio wrong");
    a_bank_pick: assert property ($past(bank_sel) |-> o_coarse_tune_voltage == $past(bank_r[1][0][15:11]))
        else $error("second bank not used");
    a_pump_source: assert property (o_pump_current == $past(autobw ? i_osc_gain_code : act_pmp[4:0]))
        else $error("pump current source wrong");
    a_amp_pin: assert property (o_amp_enable == $past(cfg_one_r[0]) && o_filter_pin_oe == o_amp_enable)
        else $error("amplifier and pin drive disagree");
    a_bus_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("waitrequest did not drop");

    c_cal_ok: cover property (core.done && !cal_fail);
    c_cal_fail: cover property (core.done && cal_fail);
    c_reg_write: cover property (wr_take && bank_hit);
    c_locked: cover property ($rose(o_lock_enable));
endmodule : fns_synth_ctrl

// file: pkg/fns_regs.svh
`ifndef FNS_REGS_SVH
`define FNS_REGS_SVH
// Register byte offsets on the Avalon-MM slave.
`define FNS_OFF_BANK_CFG 7'h00
`define FNS_OFF_BANK_INT 7'h04
`define FNS_OFF_BANK_FRU 7'h08
`define FNS_OFF_BANK_FRL 7'h0c
`define FNS_OFF_BANK_PMP 7'h10
`define FNS_BANK2_BASE 7'h20
`define FNS_OFF_CFG_ONE 7'h40
`define FNS_OFF_CFG_FIVE 7'h44
`define FNS_OFF_READBACK 7'h48
// Field positions.
`define FNS_F_OSC_SEL 0
`define FNS_F_LO_DIV 2
`define FNS_F_CAL_EN 3
`define FNS_F_DEF_BAND 4
`define FNS_F_CT_V 11
`define FNS_F_LOW_I 5
`define FNS_F_AUTO_BW 6
`define FNS_F_FLL 7
`define FNS_F_VCOI 9
`define FNS_F_ACTIVE_FILTER_ENABLE 0
`define FNS_F_PDP 1
`define FNS_F_BYP 2
`define FNS_F_RDIV 13
// Reset values.
`define FNS_RST_BANK_CFG 16'h8009
`define FNS_RST_BANK_PMP 16'h009f
`define FNS_RST_CFG_ONE 16'h4003
`define FNS_RST_ZERO 16'h0000
// Band limits and calibration timing in phase detector cycles.
`define FNS_BAND_MIN 7'h00
`define FNS_BAND_MAX 7'h7f
`define FNS_CAL_PD_CYCLES 1500
`define FNS_CAL_STEPS 7
`define FNS_CAL_STEP_CYCLES (`FNS_CAL_PD_CYCLES / `FNS_CAL_STEPS)
`endif

// file: pkg/fns_pkg.sv
package fns_pkg;
    typedef logic [6:0] fns_band_t;
    typedef logic [9:0] fns_int_t;
    typedef logic [23:0] fns_frac_t;
    typedef enum logic {CAL_IDLE, CAL_SEARCH} fns_cal_state_e;
endpackage : fns_pkg

// file: pkg/fns_core_if.sv
`timescale 1ns/1ps
interface fns_core_if;
    import fns_pkg::*;
    logic start;
    logic pd_tick;
    logic osc_fast;
    logic busy;
    logic done;
    fns_band_t trial_band;
    fns_band_t result;
    fns_int_t int_word;
    fns_frac_t frac_word;
    fns_int_t ratio;
    modport top (output start, pd_tick, osc_fast, int_word, frac_word,
                 input busy, done, trial_band, result, ratio);
    modport cal (input start, pd_tick, osc_fast, output busy, done, trial_band, result);
    modport frac (input pd_tick, int_word, frac_word, output ratio);
endinterface : fns_core_if

// file: hw/fns_band_cal.sv
`timescale 1ns/1ps
`include "fns_regs.svh"
module fns_band_cal import fns_pkg::*; #(
    parameter int STEP_CYCLES = `FNS_CAL_STEP_CYCLES
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Calibration group
    fns_core_if.cal cal
);
    localparam int STEP_W = $clog2(STEP_CYCLES);
    fns_cal_state_e state_r;
    logic [STEP_W-1:0] step_r;
    logic [2:0] bit_r;
    fns_band_t trial_r;
    fns_band_t result_r;
    logic done_r;
    logic finish;
    logic [10:0] tick_cnt_r;

    assign finish = state_r == CAL_SEARCH && cal.pd_tick && !cal.start
                    && step_r == STEP_W'(STEP_CYCLES - 1) && bit_r == 3'h0;

    // Successive approximation, one band bit per step, a new start restarts it.
    always_ff @(posedge i_core_clk) begin : p_search
        if (!i_reset_n) begin
            state_r <= CAL_IDLE;
            step_r <= '0;
            bit_r <= 3'h6;
            trial_r <= 7'h40;
        end else if (cal.start) begin
            state_r <= CAL_SEARCH;
            step_r <= '0;
            bit_r <= 3'h6;
            trial_r <= 7'h40;
        end else begin
            case (state_r)
                CAL_SEARCH: begin
                    if (cal.pd_tick) begin
                        if (step_r == STEP_W'(STEP_CYCLES - 1)) begin
                            step_r <= '0;
                            trial_r[bit_r] <= cal.osc_fast;
                            if (bit_r == 3'h0) begin
                                state_r <= CAL_IDLE;
                            end else begin
                                bit_r <= bit_r - 3'h1;
                                trial_r[bit_r - 3'h1] <= 1'b1;
                            end
                        end else begin
                            step_r <= step_r + 1'b1;
                        end
                    end
                end
                default: state_r <= CAL_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin : p_result
        if (!i_reset_n) begin
            result_r <= `FNS_BAND_MIN;
            done_r <= 1'b0;
        end else begin
            done_r <= finish;
            if (finish) begin
                result_r <= {trial_r[6:1], cal.osc_fast};
            end
        end
    end

    assign cal.busy = state_r == CAL_SEARCH;
    assign cal.done = done_r;
    assign cal.trial_band = trial_r;
    assign cal.result = result_r;

    always_ff @(posedge i_core_clk) begin : p_tick_count
        if (!i_reset_n || cal.start) begin
            tick_cnt_r <= 11'h000;
        end else if (cal.busy && cal.pd_tick) begin
            tick_cnt_r <= tick_cnt_r + 11'h001;
        end
    end

    a_cal_length: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        done_r |-> tick_cnt_r == 11'(`FNS_CAL_STEPS * STEP_CYCLES))
        else $error("band selection length wrong");
    a_result_hold: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        $changed(result_r) |-> done_r)
        else $error("band result changed without completion");
endmodule : fns_band_cal

// file: hw/fns_frac_seq.sv
`timescale 1ns/1ps
module fns_frac_seq import fns_pkg::*; (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Divider group
    fns_core_if.frac frac
);
    fns_frac_t acc_r;
    fns_int_t ratio_r;
    logic [24:0] sum;

    assign sum = {1'b0, acc_r} + {1'b0, frac.frac_word};

    // First-order accumulator; its carry picks the N+1 modulus.
    always_ff @(posedge i_core_clk) begin : p_accum
        if (!i_reset_n) begin
            acc_r <= 24'h000000;
            ratio_r <= 10'h000;
        end else if (frac.pd_tick) begin
            acc_r <= sum[23:0];
            ratio_r <= frac.int_word + fns_int_t'(sum[24]);
        end
    end

    assign frac.ratio = ratio_r;

    a_ratio_pick: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        frac.pd_tick |=> (ratio_r == $past(frac.int_word) || ratio_r == $past(frac.int_word) + 10'h001))
        else $error("feedback ratio not N or N+1");
endmodule : fns_frac_seq

// file: bench/test_fns_synth_ctrl.sv
`timescale 1ns/1ps
module test_fns_synth_ctrl;
    logic clk = 0, rst_n = 0, rd = 0, wr = 0, ce = 0, mode = 1, pd = 0, fast = 1;
    logic [6:0] addr = 7'h00;
    logic [31:0] wd = 32'h0, rdata, q;
    logic [1:0] pdc = 2'h0, fll;
    logic [2:0] osc_en, rdiv;
    logic [6:0] band;
    logic [4:0] ctv, pump;
    logic [3:0] vcoi, lobuf;
    logic [9:0] fbr;
    logic wait_r, div4, lowi, amp, oe, detector_polarity, busy, lock;
    int failures = 0, total_checks = 0, n, hi, bad;
    logic trk = 0, fix = 1;
    always #50 clk = ~clk;
    // Phase detector clock of eight core cycles, each level four cycles long.
    always @(posedge clk) begin
        pdc <= pdc + 2'h1;
        if (pdc == 2'h3) pd <= ~pd;
    end
    // Comparator model: the oscillator runs fast while the band sits below the tuned point.
    always @(posedge clk) fast <= trk ? (band < 7'h2a) : fix;
    fns_synth_ctrl fns_synth_ctrl_i (.i_core_clk(clk), .i_reset_n(rst_n), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'h3),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_r), .i_chip_enable_pin(ce), .i_mode_pin(mode),
        .i_pd_clk(pd), .i_osc_fast(fast), .i_osc_gain_code(5'h0a), .o_osc_enable(osc_en),
        .o_osc_band(band), .o_coarse_tune_voltage(ctv), .o_osc_core_current(vcoi), .o_lo_div4(div4),
        .o_lo_buffer_current(lobuf), .o_ref_div_ratio(rdiv), .o_feedback_ratio(fbr), .o_pump_current(pump),
        .o_pump_low_current(lowi), .o_freq_loop_factor(fll), .o_amp_enable(amp), .o_filter_pin_oe(oe),
        .o_detector_polarity(detector_polarity), .o_cal_busy(busy), .o_lock_enable(lock));
    task automatic close_out;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // The request is held until waitrequest is sampled low, then released.
    task automatic bus(input logic w, input logic [6:0] a, input logic [15:0] d);
        n = 0;
        @(posedge clk);
        addr <= a;
        wd <= {16'h0, d};
        rd <= ~w;
        wr <= w;
        do begin
            @(posedge clk);
            n++;
        end while (wait_r !== 1'b0 && n < 50);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        chk(32'(n < 50), 32'h1);
    endtask : bus
    task automatic settle;
        repeat (6) @(posedge clk);
    endtask : settle
    task automatic t_reset;
        @(negedge clk);
        chk(32'(osc_en), 32'h1);
        chk(32'(ctv), 32'h10);
        chk({pump, lowi}, {26'h0, 5'h1f, 1'b0});
        chk(32'(fll), 32'h1);
        chk({amp, oe, detector_polarity}, 32'h7);
        bus(0, 7'h20, 16'h0);
        chk(q, 32'h8009);
        bus(0, 7'h30, 16'h0);
        chk(q, 32'h009f);
        bus(0, 7'h40, 16'h0);
        chk(q, 32'h4003);
        $display("test reset done");
    endtask : t_reset
    task automatic t_osc;
        for (int s = 1; s < 4; s++) begin
            bus(1, 7'h20, {5'h0c, 7'h15, 1'b0, s[0], 2'(s)});
            settle();
            chk(32'(osc_en), 32'(1 << (s - 1)));
            chk({band, ctv, div4}, {19'h0, 7'h15, 5'h0c, s[0]});
        end
        $display("test oscillator select done");
    endtask : t_osc
    task automatic t_ref;
        bus(1, 7'h40, 16'h4007);
        settle();
        chk(32'(rdiv), 32'h1);
        for (int r = 2; r < 8; r++) begin
            bus(1, 7'h40, {3'(r), 13'h0});
            settle();
            chk(32'(rdiv), 32'(r));
            chk({amp, oe, detector_polarity}, 32'h0);
        end
        $display("test reference divider done");
    endtask : t_ref
    task automatic t_bank;
        mode <= 1'b0;
        bus(1, 7'h00, {5'h10, 7'h33, 4'h2});
        settle();
        chk({osc_en, band}, {22'h0, 3'h2, 7'h33});
        mode <= 1'b1;
        settle();
        chk({osc_en, band}, {22'h0, 3'h4, 7'h15});
        $display("test bank select done");
    endtask : t_bank
    task automatic t_pump;
        bus(1, 7'h30, 16'h18a5);
        settle();
        chk({pump, lowi, fll}, {24'h0, 5'h05, 1'b1, 2'h1});
        chk(32'(vcoi), 32'hc);
        bus(1, 7'h44, 16'h000c);
        settle();
        chk(32'(lobuf), 32'hc);
        bus(1, 7'h30, 16'h0065);
        settle();
        chk({pump, lowi, fll}, {24'h0, 5'h0a, 1'b1, 2'h0});
        $display("test pump done");
    endtask : t_pump
    task automatic t_frac;
        bus(1, 7'h24, 16'h0064);
        bus(1, 7'h28, 16'h8000);
        bus(1, 7'h2c, 16'h0000);
        settle();
        hi = 0;
        bad = 0;
        repeat (400) begin
            @(posedge clk);
            if (fbr === 10'h065) hi++;
            else if (fbr !== 10'h064) bad++;
        end
        chk(32'(bad), 32'h0);
        chk(32'(hi > 150 && hi < 250), 32'h1);
        $display("test fraction done");
    endtask : t_frac
    task automatic t_unmap;
        bus(1, 7'h7c, 16'h1234);
        bus(0, 7'h7c, 16'h0);
        chk(q, 32'h0);
        bus(0, 7'h01, 16'h0);
        chk(q, 32'h0);
        bus(1, 7'h48, 16'hffff);
        bus(0, 7'h48, 16'h0);
        chk(q, 32'h0300);
        $display("test unmapped done");
    endtask : t_unmap
    task automatic t_cal(input logic t, input logic f, input logic [6:0] res, input logic [6:0] old);
        bus(1, 7'h20, 16'h8009);
        trk <= t;
        fix <= f;
        settle();
        ce <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (busy !== 1'b1 && n < 20);
        @(posedge clk);
        chk({busy, lock, band}, {23'h0, 2'b10, 7'h40});
        bus(0, 7'h48, 16'h0);
        chk(32'(q[7:0]), {24'h0, 1'b1, old});
        n = 0;
        while (busy !== 1'b0 && n < 16000) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n > 11000 && n < 13500), 32'h1);
        settle();
        chk(32'(lock), 32'h1);
        bus(0, 7'h48, 16'h0);
        chk(32'(q[8:0]), {23'h0, (res == 7'h00 || res == 7'h7f), 1'b0, res});
        chk(32'(band), 32'(res));
        ce <= 1'b0;
        settle();
        $display("test calibration done");
    endtask : t_cal
    initial begin
        #6000000;
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        close_out();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_osc();
        t_ref();
        t_bank();
        t_pump();
        t_frac();
        t_unmap();
        t_cal(1'b0, 1'b1, 7'h7f, 7'h00);
        t_cal(1'b0, 1'b0, 7'h00, 7'h7f);
        t_cal(1'b1, 1'b0, 7'h29, 7'h00);
        close_out();
    end
endmodule : test_fns_synth_ctrl
